// ---- verilog/spi_error_flag_logic.sv ----
// SPI status flags, error detection and interrupt requests
//
// Overview of operation
// - Data write during transfer sets write collision
// - Collision raises no interrupt; transfer continues
// - Status access then data access clears collision
// - Overrun keeps first byte until flag clear
// - Overrun is not detected nor flagged
// - Slave select rising mid-byte sets select error
// - Select error no interrupt; cleared by enable=0
// - Transfer complete drives transmitter interrupt
// - Mode fault drives error interrupt if not disabled
// - Master select low: mode fault, clear enable, master
// - Status read with fault then control write clears
`timescale 1ns/1ps
module spi_error_flag_logic
  import spi_err_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic sck,
  input wire logic ss_n,
  input wire logic mosi,
  input wire logic sta_rd,
  input wire logic dat_rd,
  input wire logic dat_wr,
  input wire logic [7:0] dat_wdata,
  input wire logic ctl_wr,
  input wire logic [7:0] ctl_wdata,
  input wire logic master_busy,
  input wire logic master_done,
  input wire logic [7:0] master_rx_data,
  output logic [7:0] spi_status_reg,
  output logic [7:0] spi_control_reg,
  output logic [7:0] rx_data,
  output logic [7:0] tx_data,
  output logic tx_load,
  output logic tx_irq,
  output logic rxerr_irq,
  output logic spi_enable_bit,
  output logic master_select_bit,
  output logic select_disable_bit
);

  // ----------------------------------------------------------------
  // Link side receiver
  // ----------------------------------------------------------------
  logic link_rst_q, link_rst_d;
  logic [7:0] link_byte;
  logic link_start_tgl, link_done_tgl;

  spi_link_rx #(.WIDTH(8)) u_link_rx (
    .sck(sck),
    .link_rst(link_rst_q),
    .ss_n(ss_n),
    .mosi(mosi),
    .rx_byte(link_byte),
    .start_tgl(link_start_tgl),
    .done_tgl(link_done_tgl)
  );

  // ----------------------------------------------------------------
  // Clock domain crossing
  // ----------------------------------------------------------------
  logic ss_s1_q, ss_s2_q, ss_s3_q;
  logic st_s1_q, st_s2_q, st_s3_q;
  logic dn_s1_q, dn_s2_q, dn_s3_q;
  logic ss_rise, start_evt, slave_done_evt;

  // Two-stage synchronisers plus one stage for edge detection
  always_ff @(posedge clk) begin
    if (srst) begin
      ss_s1_q <= SS_IDLE_LEVEL;
      ss_s2_q <= SS_IDLE_LEVEL;
      ss_s3_q <= SS_IDLE_LEVEL;
      st_s1_q <= 1'b0;
      st_s2_q <= 1'b0;
      st_s3_q <= 1'b0;
      dn_s1_q <= 1'b0;
      dn_s2_q <= 1'b0;
      dn_s3_q <= 1'b0;
    end else begin
      ss_s1_q <= ss_n;
      ss_s2_q <= ss_s1_q;
      ss_s3_q <= ss_s2_q;
      st_s1_q <= link_start_tgl;
      st_s2_q <= st_s1_q;
      st_s3_q <= st_s2_q;
      dn_s1_q <= link_done_tgl;
      dn_s2_q <= dn_s1_q;
      dn_s3_q <= dn_s2_q;
    end
  end

  assign ss_rise = ss_s2_q & ~ss_s3_q;
  assign start_evt = st_s2_q ^ st_s3_q;
  assign slave_done_evt = dn_s2_q ^ dn_s3_q;

  // ----------------------------------------------------------------
  // Control, flags and data
  // ----------------------------------------------------------------
  logic [7:0] ctl_q, ctl_d;
  logic done_q, done_d;
  logic coll_q, coll_d;
  logic selerr_q, selerr_d;
  logic mflt_q, mflt_d;
  logic coll_arm_q, coll_arm_d;
  logic done_arm_q, done_arm_d;
  logic mflt_arm_q, mflt_arm_d;
  logic [7:0] rx_q, rx_d;
  logic [7:0] tx_q, tx_d;
  logic tx_load_q, tx_load_d;
  logic tx_irq_q, tx_irq_d;
  logic rxerr_q, rxerr_d;
  link_state_t slv_q, slv_d;
  logic en, mst_mode, sel_dis, busy, done_evt, dat_acc, fault;

  assign en = ctl_q[CTRL_EN_BIT];
  assign mst_mode = ctl_q[CTRL_MASTER_BIT];
  assign sel_dis = ctl_q[CTRL_SELDIS_BIT];
  assign busy = mst_mode ? master_busy : (slv_q == LINK_BYTE);
  assign done_evt = en & (mst_mode ? master_done : slave_done_evt);
  assign dat_acc = dat_rd | dat_wr;
  assign fault = en & mst_mode & ~sel_dis & ~ss_s2_q;

  // Next values of every flag, control bit and data holder
  always_comb begin
    ctl_d = ctl_q;
    done_d = done_q;
    coll_d = coll_q;
    selerr_d = selerr_q;
    mflt_d = mflt_q;
    coll_arm_d = coll_arm_q;
    done_arm_d = done_arm_q;
    mflt_arm_d = mflt_arm_q;
    rx_d = rx_q;
    tx_d = tx_q;
    tx_load_d = 1'b0;
    slv_d = slv_q;
    link_rst_d = ~en;
    // Control write; mode fault clear needs prior status read
    if (ctl_wr) begin
      ctl_d = ctl_wdata;
      if (!ctl_wdata[CTRL_EN_BIT]) begin
        selerr_d = 1'b0;
        slv_d = LINK_IDLE;
      end
      if (mflt_arm_q) begin
        mflt_d = 1'b0;
        mflt_arm_d = 1'b0;
      end
    end
    // Status read arms the clearing sequences
    if (sta_rd) begin
      coll_arm_d = 1'b1;
      done_arm_d = 1'b1;
      if (mflt_q) begin
        mflt_arm_d = 1'b1;
      end
    end
    // Data access completes the collision and done clearing sequences
    if (dat_acc && coll_arm_q) begin
      coll_d = 1'b0;
      coll_arm_d = 1'b0;
    end
    if (dat_acc && done_arm_q) begin
      done_d = 1'b0;
      done_arm_d = 1'b0;
    end
    // Data write: loads only when idle, else collision
    if (dat_wr) begin
      if (busy) begin
        coll_d = 1'b1;
      end else begin
        tx_d = dat_wdata;
        tx_load_d = 1'b1;
      end
    end
    // Slave byte tracking from the link events
    if (start_evt) begin
      slv_d = LINK_BYTE;
    end
    if (slave_done_evt) begin
      slv_d = LINK_IDLE;
    end
    // Select released mid-byte in slave mode
    if (ss_rise) begin
      if (en && !mst_mode && slv_q == LINK_BYTE && !slave_done_evt) begin
        selerr_d = 1'b1;
      end
      slv_d = LINK_IDLE;
    end
    // Byte complete; later bytes are dropped silently
    if (done_evt) begin
      done_d = 1'b1;
      if (!done_q) begin
        rx_d = mst_mode ? master_rx_data : link_byte;
      end
    end
    // Mode fault wins over any control write this cycle
    if (fault) begin
      mflt_d = 1'b1;
      ctl_d[CTRL_EN_BIT] = 1'b0;
      ctl_d[CTRL_MASTER_BIT] = 1'b0;
    end
    if (!ctl_d[CTRL_EN_BIT]) begin
      slv_d = LINK_IDLE;
    end
    tx_irq_d = done_d;
    rxerr_d = mflt_d & ~ctl_d[CTRL_SELDIS_BIT];
  end

  // Register stage of the flag group
  always_ff @(posedge clk) begin
    if (srst) begin
      ctl_q <= CONTROL_RESET;
      done_q <= 1'b0;
      coll_q <= 1'b0;
      selerr_q <= 1'b0;
      mflt_q <= 1'b0;
      coll_arm_q <= 1'b0;
      done_arm_q <= 1'b0;
      mflt_arm_q <= 1'b0;
      rx_q <= DATA_RESET;
      tx_q <= DATA_RESET;
      tx_load_q <= 1'b0;
      tx_irq_q <= 1'b0;
      rxerr_q <= 1'b0;
      slv_q <= LINK_IDLE;
      link_rst_q <= LINK_RESET_ACTIVE;
    end else begin
      ctl_q <= ctl_d;
      done_q <= done_d;
      coll_q <= coll_d;
      selerr_q <= selerr_d;
      mflt_q <= mflt_d;
      coll_arm_q <= coll_arm_d;
      done_arm_q <= done_arm_d;
      mflt_arm_q <= mflt_arm_d;
      rx_q <= rx_d;
      tx_q <= tx_d;
      tx_load_q <= tx_load_d;
      tx_irq_q <= tx_irq_d;
      rxerr_q <= rxerr_d;
      slv_q <= slv_d;
      link_rst_q <= link_rst_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Status image built from flag flops only
  always_comb begin
    spi_status_reg = 8'h00;
    spi_status_reg[STAT_DONE_BIT] = done_q;
    spi_status_reg[STAT_COLL_BIT] = coll_q;
    spi_status_reg[STAT_SELERR_BIT] = selerr_q;
    spi_status_reg[STAT_FAULT_BIT] = mflt_q;
  end

  assign spi_control_reg = ctl_q;
  assign rx_data = rx_q;
  assign tx_data = tx_q;
  assign tx_load = tx_load_q;
  assign tx_irq = tx_irq_q;
  assign rxerr_irq = rxerr_q;
  assign spi_enable_bit = ctl_q[CTRL_EN_BIT];
  assign master_select_bit = ctl_q[CTRL_MASTER_BIT];
  assign select_disable_bit = ctl_q[CTRL_SELDIS_BIT];

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  a_coll_busy_write: assert property (
    dat_wr && busy |=> coll_q
  ) else $error("write collision not flagged");

  a_coll_keeps_tx: assert property (
    dat_wr && busy |=> $stable(tx_data) && !tx_load && (tx_irq == done_q)
  ) else $error("collision disturbed the transfer");

  a_coll_clear_seq: assert property (
    sta_rd ##1 (dat_acc && !(dat_wr && busy)) |=> !coll_q
  ) else $error("write collision not cleared by sequence");

  a_rx_first_kept: assert property (
    done_q && done_evt |=> rx_data == $past(rx_data)
  ) else $error("overrun replaced the held byte");

  a_overrun_silent: assert property (
    done_q && done_evt && !dat_acc && !ctl_wr && !ss_rise && !fault
    |=> $stable(spi_status_reg)
  ) else $error("overrun changed a status bit");

  a_selerr_set: assert property (
    ss_rise && en && !mst_mode && slv_q == LINK_BYTE && !slave_done_evt |=> selerr_q
  ) else $error("select error not flagged");

  a_selerr_hold: assert property (
    selerr_q && !(ctl_wr && !ctl_wdata[CTRL_EN_BIT]) |=> selerr_q && !rxerr_irq
      || selerr_q && mflt_q
  ) else $error("select error lost without enable clear");

  a_tx_irq_map: assert property (
    $rose(done_q) |-> tx_irq ##1 (tx_irq == done_q)
  ) else $error("transmitter request does not follow flag");

  a_rxerr_map: assert property (
    rxerr_irq == (mflt_q && !sel_dis)
  ) else $error("error request does not follow mode fault");

  a_fault_set: assert property (
    fault |=> mflt_q && !spi_enable_bit && !master_select_bit
  ) else $error("mode fault not handled");

  a_fault_clear: assert property (
    sta_rd && mflt_q ##1 (ctl_wr && !sta_rd && !fault) |=> !mflt_q
  ) else $error("mode fault not cleared by sequence");

  c_collision: cover property (dat_wr && busy);
  c_overrun: cover property (done_q && done_evt);
  c_select_error: cover property (ss_rise && en && !mst_mode && slv_q == LINK_BYTE);
  c_mode_fault: cover property (fault ##1 rxerr_irq);

endmodule

// ---- verilog/spi_err_pkg.sv ----
// Shared constants and types for the SPI error and flag logic
package spi_err_pkg;

  // ----------------------------------------------------------------
  // Status register bit positions
  // ----------------------------------------------------------------
  localparam int STAT_DONE_BIT = 7;
  localparam int STAT_COLL_BIT = 6;
  localparam int STAT_SELERR_BIT = 5;
  localparam int STAT_FAULT_BIT = 4;

  // ----------------------------------------------------------------
  // Control register bit positions
  // ----------------------------------------------------------------
  localparam int CTRL_EN_BIT = 6;
  localparam int CTRL_SELDIS_BIT = 5;
  localparam int CTRL_MASTER_BIT = 4;

  // ----------------------------------------------------------------
  // Values after reset
  // ----------------------------------------------------------------
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic SS_IDLE_LEVEL = 1'b1;
  localparam logic LINK_RESET_ACTIVE = 1'b1;

  // ----------------------------------------------------------------
  // Slave byte tracking in the system clock domain
  // ----------------------------------------------------------------
  typedef enum logic {
    LINK_IDLE = 1'b0,
    LINK_BYTE = 1'b1
  } link_state_t;

endpackage

// ---- verilog/spi_link_rx.sv ----
// Serial-clock-domain byte receiver with start and done toggles
`timescale 1ns/1ps
module spi_link_rx
  import spi_err_pkg::*;
#(
  parameter int WIDTH = 8
) (
  input wire logic sck,
  input wire logic link_rst,
  input wire logic ss_n,
  input wire logic mosi,
  output logic [WIDTH-1:0] rx_byte,
  output logic start_tgl,
  output logic done_tgl
);

  // ----------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------
  if (WIDTH < 2 || WIDTH > 16) begin : g_width_check
    $error("spi_link_rx: WIDTH must lie between 2 and 16");
  end

  localparam int CW = $clog2(WIDTH);
  localparam logic [CW-1:0] LAST_BIT = CW'(WIDTH - 1);

  logic [CW-1:0] bit_cnt_q, bit_cnt_d;
  logic [WIDTH-1:0] shift_q, shift_d;
  logic [WIDTH-1:0] byte_q, byte_d;
  logic start_q, start_d;
  logic done_q, done_d;
  logic cnt_clr;

  // Frame end or link reset clears the partial byte
  assign cnt_clr = link_rst | ss_n;

  // Next state of shifter, bit counter and event toggles
  always_comb begin
    shift_d = {shift_q[WIDTH-2:0], mosi};
    bit_cnt_d = bit_cnt_q + CW'(1);
    byte_d = byte_q;
    start_d = start_q;
    done_d = done_q;
    if (bit_cnt_q == '0) begin
      start_d = ~start_q;
    end
    if (bit_cnt_q == LAST_BIT) begin
      bit_cnt_d = '0;
      byte_d = {shift_q[WIDTH-2:0], mosi};
      done_d = ~done_q;
    end
  end

  // Bit position, reset by the frame's own select signal
  always_ff @(posedge sck or posedge cnt_clr) begin
    if (cnt_clr) begin
      bit_cnt_q <= '0;
      shift_q <= '0;
    end else begin
      bit_cnt_q <= bit_cnt_d;
      shift_q <= shift_d;
    end
  end

  // Completed byte and toggles survive the end of a frame
  always_ff @(posedge sck or posedge link_rst) begin
    if (link_rst) begin
      byte_q <= '0;
      start_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      byte_q <= byte_d;
      start_q <= start_d;
      done_q <= done_d;
    end
  end

  assign rx_byte = byte_q;
  assign start_tgl = start_q;
  assign done_tgl = done_q;

endmodule

// ---- tb/spi_master_model.sv ----
// Behavioural model of the external SPI master on the serial side
`timescale 1ns/1ps
module spi_master_model (
  output logic sck,
  output logic ss_n,
  output logic mosi
);
  // ----------------------------------------------------------------
  // Idle lines: clock still, select released
  // ----------------------------------------------------------------
  initial begin
    sck = 1'b0;
    ss_n = 1'b1;
    mosi = 1'b1;
  end

  // Frame of nbits bits, MSB first; fewer than 8 aborts the byte mid-way
  task automatic send(input logic [7:0] d, input int nbits);
    int i;
    #24;
    ss_n = 1'b0;
    #20;
    for (i = 0; i < nbits; i++) begin
      mosi = d[7-i];
      #16 sck = 1'b1;
      #16 sck = 1'b0;
    end
    #20 ss_n = 1'b1; // Early release when nbits < 8
    mosi = ~mosi; // Released line shows no stale bit
  endtask

  // Hold select low as a competing master would
  task automatic select_low();
    ss_n = 1'b0;
    mosi = ~mosi;
  endtask

  task automatic release_sel();
    ss_n = 1'b1;
    mosi = ~mosi;
  endtask
endmodule

// ---- tb/spi_error_flag_logic_tb.sv ----
// Self-checking bench for the SPI status flag logic
`timescale 1ns/1ps
module spi_error_flag_logic_tb;
  import spi_err_pkg::*;
  logic clk, srst, sck, ss_n, mosi, sta_rd, dat_rd, dat_wr, ctl_wr;
  logic master_busy, master_done, tx_load, tx_irq, rxerr_irq;
  logic spi_enable_bit, master_select_bit, select_disable_bit;
  logic [7:0] dat_wdata, ctl_wdata, master_rx_data;
  logic [7:0] spi_status_reg, spi_control_reg, rx_data, tx_data;
  int miscompares = 0;
  int checks_done = 0;

  spi_error_flag_logic dut (.clk(clk), .srst(srst), .sck(sck), .ss_n(ss_n), .mosi(mosi),
    .sta_rd(sta_rd), .dat_rd(dat_rd), .dat_wr(dat_wr), .dat_wdata(dat_wdata),
    .ctl_wr(ctl_wr), .ctl_wdata(ctl_wdata), .master_busy(master_busy),
    .master_done(master_done), .master_rx_data(master_rx_data),
    .spi_status_reg(spi_status_reg), .spi_control_reg(spi_control_reg), .rx_data(rx_data),
    .tx_data(tx_data), .tx_load(tx_load), .tx_irq(tx_irq), .rxerr_irq(rxerr_irq),
    .spi_enable_bit(spi_enable_bit), .master_select_bit(master_select_bit),
    .select_disable_bit(select_disable_bit));
  spi_master_model partner (.sck(sck), .ss_n(ss_n), .mosi(mosi));

  // ----------------------------------------------------------------
  // Clock and shared helpers
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (exp !== got) begin
      miscompares++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  // One register access pulse, then let its effect land
  task automatic reg_op(input logic s, input logic r, input logic w, input logic c,
                        input logic [7:0] wd);
    sta_rd = s;
    dat_rd = r;
    dat_wr = w;
    ctl_wr = c;
    dat_wdata = wd;
    ctl_wdata = wd;
    cyc(1);
    {sta_rd, dat_rd, dat_wr, ctl_wr} = 4'h0;
    cyc(2);
  endtask

  // Status read, then a data read (c=0) or control write (c=1) on the next edge
  task automatic rd_then(input logic c, input logic [7:0] wd);
    sta_rd = 1'b1;
    cyc(1);
    sta_rd = 1'b0;
    dat_rd = ~c;
    ctl_wr = c;
    ctl_wdata = wd;
    cyc(1);
    {dat_rd, ctl_wr} = 2'h0;
    cyc(2);
  endtask

  // Data write pulse; load strobe checked in the cycle it stands
  task automatic wr_dat(input logic [7:0] d, input logic ld);
    dat_wr = 1'b1;
    dat_wdata = d;
    cyc(1);
    dat_wr = 1'b0;
    chk("tx_load", {7'h0, ld}, {7'h0, tx_load});
    cyc(2);
  endtask

  task automatic wait_bit(input int idx);
    int n;
    for (n = 0; n < 200 && spi_status_reg[idx] !== 1'b1; n++) cyc(1);
    if (n == 200) begin
      miscompares++;
      $display("Error status bit %0d expected 1 seen %b", idx, spi_status_reg[idx]);
      finish_test();
    end
    cyc(2);
  endtask

  task automatic finish_test();
    $display("checks_done %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_overrun();
    reg_op(0, 0, 0, 1, 8'h40);
    cyc(4);
    partner.send(8'ha5, 8);
    wait_bit(STAT_DONE_BIT);
    chk("rx_data", 8'ha5, rx_data);
    chk("tx_irq", 8'h01, {7'h0, tx_irq});
    partner.send(8'h3c, 8);
    partner.send(8'h5a, 8);
    cyc(10);
    chk("rx_data kept", 8'ha5, rx_data);
    chk("status overrun", 8'h80, spi_status_reg);
    rd_then(1'b0, 8'h00);
    chk("status cleared", 8'h00, spi_status_reg);
    chk("tx_irq low", 8'h00, {7'h0, tx_irq});
    partner.send(8'h3c, 8);
    wait_bit(STAT_DONE_BIT);
    chk("rx_data next", 8'h3c, rx_data);
    rd_then(1'b0, 8'h00);
  endtask

  task automatic t_collision();
    reg_op(0, 0, 0, 1, 8'h50);
    wr_dat(8'h5a, 1'b1);
    chk("tx_data", 8'h5a, tx_data);
    master_busy = 1'b1;
    wr_dat(8'h11, 1'b0);
    chk("status coll", 8'h40, spi_status_reg);
    chk("tx_data kept", 8'h5a, tx_data);
    chk("irqs", 8'h00, {6'h0, tx_irq, rxerr_irq});
    reg_op(0, 1, 0, 0, 8'h00);
    chk("coll no order", 8'h40, spi_status_reg);
    master_rx_data = 8'h77;
    master_done = 1'b1;
    cyc(1);
    master_done = 1'b0;
    master_busy = 1'b0;
    cyc(2);
    chk("status done", 8'hc0, spi_status_reg);
    chk("rx master", 8'h77, rx_data);
    rd_then(1'b0, 8'h00);
    chk("coll cleared", 8'h00, spi_status_reg);
  endtask

  task automatic t_mode_fault();
    partner.select_low();
    wait_bit(STAT_FAULT_BIT);
    chk("status fault", 8'h10, spi_status_reg);
    chk("control fault", 8'h00, spi_control_reg);
    chk("en master", 8'h00, {6'h0, spi_enable_bit, master_select_bit});
    chk("rxerr", 8'h01, {7'h0, rxerr_irq});
    partner.release_sel();
    reg_op(0, 0, 0, 1, 8'h20);
    chk("fault held", 8'h10, spi_status_reg);
    chk("select disable", 8'h01, {7'h0, select_disable_bit});
    chk("rxerr gated", 8'h00, {7'h0, rxerr_irq});
    rd_then(1'b1, 8'h00);
    chk("fault cleared", 8'h00, spi_status_reg);
    reg_op(0, 0, 0, 1, 8'h70);
    partner.select_low();
    cyc(10);
    chk("no fault", 8'h00, spi_status_reg);
    chk("en kept", 8'h01, {7'h0, spi_enable_bit});
    partner.release_sel();
    reg_op(0, 0, 0, 1, 8'h00);
  endtask

  task automatic t_select_error();
    reg_op(0, 0, 0, 1, 8'h40);
    cyc(4);
    partner.send(8'hc3, 4);
    wait_bit(STAT_SELERR_BIT);
    chk("status selerr", 8'h20, spi_status_reg);
    chk("no irq", 8'h00, {6'h0, tx_irq, rxerr_irq});
    reg_op(1, 0, 0, 0, 8'h00);
    reg_op(0, 1, 0, 0, 8'h00);
    reg_op(0, 0, 0, 1, 8'h40);
    chk("selerr held", 8'h20, spi_status_reg);
    reg_op(0, 0, 0, 1, 8'h00);
    chk("selerr cleared", 8'h00, spi_status_reg);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    srst = 1'b1;
    {sta_rd, dat_rd, dat_wr, ctl_wr, master_busy, master_done} = 6'h00;
    dat_wdata = 8'h00;
    ctl_wdata = 8'h00;
    master_rx_data = 8'h00;
    cyc(2);
    srst = 1'b0;
    cyc(3);
    chk("status reset", 8'h00, spi_status_reg);
    chk("control reset", CONTROL_RESET, spi_control_reg);
    t_overrun();
    t_collision();
    t_mode_fault();
    t_select_error();
    finish_test();
  end
endmodule
